// [inc/acr_pkg.sv]
package acr_pkg;

    // Core clock rate and derived cycle counts.
    localparam longint CLK_HZ = 100_000_000;
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint CYC_PER_MS = CLK_HZ / 1000;
    localparam int CNT_W = 40;

    // Conversion times in milliseconds, one per speed code.
    localparam longint CONV_T0_MS = 24;
    localparam longint CONV_T1_MS = 12;
    localparam longint CONV_T2_MS = 6;
    localparam longint CONV_T3_MS = 3;
    localparam logic [CNT_W-1:0] CONV_CYC0 = CNT_W'(CONV_T0_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] CONV_CYC1 = CNT_W'(CONV_T1_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] CONV_CYC2 = CNT_W'(CONV_T2_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] CONV_CYC3 = CNT_W'(CONV_T3_MS * CYC_PER_MS);

    // Periodic read intervals in seconds.
    localparam longint PERIOD_SEC_S = 1;
    localparam longint PERIOD_MIN_S = 60;
    localparam logic [CNT_W-1:0] SEC_CYC = CNT_W'(PERIOD_SEC_S * CLK_HZ);
    localparam logic [CNT_W-1:0] MIN_CYC = CNT_W'(PERIOD_MIN_S * CLK_HZ);

    // Register offsets.
    localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h40;
    localparam logic [7:0] ADDR_CMP_SOURCE = 8'h41;
    localparam logic [7:0] ADDR_VBAT_HI = 8'h42;
    localparam logic [7:0] ADDR_VBAT_LO = 8'h43;
    localparam logic [7:0] ADDR_THERM_HI = 8'h44;
    localparam logic [7:0] ADDR_THERM_LO = 8'h45;
    localparam logic [7:0] ADDR_ICHG_HI = 8'h46;
    localparam logic [7:0] ADDR_ICHG_LO = 8'h47;
    localparam logic [7:0] ADDR_AUX_HI = 8'h48;
    localparam logic [7:0] ADDR_AUX_LO = 8'h49;
    localparam logic [7:0] ADDR_VIN_HI = 8'h4a;
    localparam logic [7:0] ADDR_VIN_LO = 8'h4b;

    // Reset values.
    localparam logic [7:0] CTRL_PRIMARY_RST = 8'h02;
    localparam logic [7:0] CMP_SOURCE_RST = 8'h40;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // Field positions.
    localparam int RATE_LSB = 6;
    localparam int TRIG_BIT = 5;
    localparam int SPEED_LSB = 3;
    localparam int CMP1_LSB = 0;
    localparam int CMP2_LSB = 5;
    localparam int CMP3_LSB = 2;

    typedef enum logic [1:0] {
        RATE_MANUAL = 2'b00,
        RATE_CONT = 2'b01,
        RATE_SEC = 2'b10,
        RATE_MIN = 2'b11
    } acr_rate_e;

    typedef enum logic [2:0] {
        CH_OFF = 3'b000,
        CH_AUX = 3'b001,
        CH_THERM = 3'b010,
        CH_VBAT = 3'b011,
        CH_ICHG = 3'b100,
        CH_VIN = 3'b101,
        CH_RAIL = 3'b110,
        CH_IIN = 3'b111
    } acr_chan_e;

    typedef struct packed {
        logic [15:0] vbat;
        logic [15:0] therm;
        logic [15:0] ichg;
        logic [15:0] aux;
        logic [15:0] supply_input_voltage;
        logic [15:0] rail;
        logic [15:0] input_current;
    } acr_samples_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_reg_req_s;

endpackage

// [logic/acr_conv_timer.sv]
module acr_conv_timer #(
    parameter logic [acr_pkg::CNT_W-1:0] P_CYC0 = acr_pkg::CONV_CYC0,
    parameter logic [acr_pkg::CNT_W-1:0] P_CYC1 = acr_pkg::CONV_CYC1,
    parameter logic [acr_pkg::CNT_W-1:0] P_CYC2 = acr_pkg::CONV_CYC2,
    parameter logic [acr_pkg::CNT_W-1:0] P_CYC3 = acr_pkg::CONV_CYC3
) (
    input wire logic i_ref_clk, // Core clock.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire logic i_start, // Start pulse, honoured when idle.
    input wire logic [1:0] i_speed, // Conversion speed code.
    output logic o_busy, // Conversion in progress.
    output logic o_done // Last cycle of a conversion.
);
    localparam int W = acr_pkg::CNT_W;

    logic busy_q;
    logic [W-1:0] cnt_q;
    logic [W-1:0] dur_sel;
    logic [W-1:0] dur_q;
    logic [W-1:0] elapsed_q;

    // The speed code picks the length of one conversion.
    always_comb begin
        unique case (i_speed)
            2'b00: dur_sel = P_CYC0; // [R03]
            2'b01: dur_sel = P_CYC1; // [R03]
            2'b10: dur_sel = P_CYC2; // [R03]
            2'b11: dur_sel = P_CYC3; // [R03]
        endcase
    end

    // Down counter; the speed is latched at start so a rewrite cannot stretch a run.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (i_start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= dur_sel - W'(1); // [R03]
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    assign o_busy = busy_q;
    assign o_done = busy_q && (cnt_q == '0);

    // Elapsed-time tracker that only the checks below read.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            elapsed_q <= '0;
            dur_q <= '0;
        end else if (i_start && !busy_q) begin
            elapsed_q <= W'(1);
            dur_q <= dur_sel;
        end else if (busy_q) begin
            elapsed_q <= elapsed_q + W'(1);
        end
    end

    chk_conv_duration: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R03]
        o_done |-> (elapsed_q == dur_q))
        else $error("conversion length differs from the selected speed");

    chk_done_ends_run: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R03]
        o_done && !i_start |=> !o_busy)
        else $error("busy still high after the done cycle");

endmodule

// [logic/acr_comparator.sv]
module acr_comparator (
    input wire logic i_ref_clk, // Core clock.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire logic i_eval, // A fresh measurement is present.
    input wire logic [2:0] i_source, // Channel code, zero disables.
    input wire logic [15:0] i_value, // Measurement of the selected channel.
    input wire logic [15:0] i_thresh, // Threshold.
    input wire logic i_polarity, // Zero fires going below, one going above.
    input wire logic i_flag_clr, // Clears the sticky flag.
    output logic o_flag, // Sticky crossing flag.
    output logic o_event // One-cycle interrupt pulse.
);
    logic side_q;
    logic flag_q;
    logic event_q;
    logic beyond;
    logic hit;

    // A crossing is the first measurement on the trigger side of the threshold.
    assign beyond = i_polarity ? (i_value > i_thresh) : (i_value < i_thresh); // [R12]
    assign hit = i_eval && (i_source != 3'h0) && beyond && !side_q; // [R12]

    // Remembers the side of the last measurement; forgotten while disabled.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || i_source == 3'h0) begin
            side_q <= 1'b0;
        end else if (i_eval) begin
            side_q <= beyond;
        end
    end

    // A new crossing wins over a clear in the same cycle.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            flag_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            event_q <= hit; // [R12]
            flag_q <= hit || (flag_q && !i_flag_clr); // [R12]
        end
    end

    assign o_flag = flag_q;
    assign o_event = event_q;

    chk_crossing_flags: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R12]
        i_eval && i_source != 3'h0 && beyond && !side_q |=> o_event && o_flag)
        else $error("crossing did not raise flag and event");

    chk_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R12]
        i_source == 3'h0 |=> !o_event)
        else $error("disabled comparator raised an event");

endmodule

// [logic/acr_top.sv]
// Notes on behaviour
// R01 - Read rate picks manual, continuous, second, minute; the code applies it only in battery-only operation and uses manual otherwise
// R02 - Host sets trigger; device clears after conversion
// R03 - Speed code selects 24, 12, 6, 3 ms
// R04 - Comparator one source field, resets to thermistor
// R05 - Comparator two source in bits 7:5
// R06 - Comparator three source in bits 4:2, off
// R07 - Battery voltage result at 0x42 and 0x43
// R08 - Thermistor result at 0x44 and 0x45
// R09 - Charge current result at 0x46 and 0x47
// R10 - Auxiliary input result at 0x48 and 0x49
// R11 - Supply input result at 0x4a and 0x4b
// R12 - Enabled comparator flags crossing per polarity
// R13 - Both result bytes update from one conversion
module acr_top #(
    parameter logic [acr_pkg::CNT_W-1:0] P_CONV0_CYC = acr_pkg::CONV_CYC0,
    parameter logic [acr_pkg::CNT_W-1:0] P_CONV1_CYC = acr_pkg::CONV_CYC1,
    parameter logic [acr_pkg::CNT_W-1:0] P_CONV2_CYC = acr_pkg::CONV_CYC2,
    parameter logic [acr_pkg::CNT_W-1:0] P_CONV3_CYC = acr_pkg::CONV_CYC3,
    parameter logic [acr_pkg::CNT_W-1:0] P_SEC_CYC = acr_pkg::SEC_CYC,
    parameter logic [acr_pkg::CNT_W-1:0] P_MIN_CYC = acr_pkg::MIN_CYC
) (
    input wire logic i_ref_clk, // Core clock, 100 MHz.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire acr_pkg::acr_reg_req_s i_reg_req, // Register access from the bus slave.
    output logic [7:0] o_reg_rdata, // Read data.
    output logic o_reg_rvalid, // Read data valid, one cycle.
    input wire logic i_bat_only, // Device runs from the battery alone.
    input wire acr_pkg::acr_samples_s i_samples, // Converter front-end values.
    input wire logic [2:0][15:0] i_cmp_thresh, // Thresholds of comparators 1..3.
    input wire logic [2:0] i_cmp_polarity, // Comparator polarities.
    input wire logic [2:0] i_cmp_flag_clr, // Flag clears.
    output logic [2:0] o_cmp_flag, // Sticky comparator flags.
    output logic [2:0] o_cmp_irq, // Comparator interrupt pulses.
    output logic o_conv_busy, // Conversion in progress.
    output logic o_conv_done // One-cycle pulse after each conversion.
);
    localparam int W = acr_pkg::CNT_W;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_WAIT = 2'b10
    } acr_sched_e;

    acr_sched_e state_q;
    logic [7:0] ctrl_q;
    logic [7:0] src_q;
    acr_pkg::acr_samples_s results_q;
    logic [W-1:0] period_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic done_q;
    logic wr_ctrl;
    logic wr_src;
    logic trig;
    logic [1:0] rate_eff;
    logic start;
    logic tmr_busy;
    logic tmr_done;
    logic [2:0][2:0] cmp_src;
    logic [W-1:0] gap_q;
    logic [1:0] gap_rate_q;
    logic gap_ok_q;

    assign wr_ctrl = i_reg_req.wr && (i_reg_req.addr == acr_pkg::ADDR_CTRL_PRIMARY);
    assign wr_src = i_reg_req.wr && (i_reg_req.addr == acr_pkg::ADDR_CMP_SOURCE);
    assign trig = ctrl_q[acr_pkg::TRIG_BIT];

    // Outside battery-only operation only the trigger starts a conversion.
    assign rate_eff = i_bat_only ? ctrl_q[acr_pkg::RATE_LSB +: 2] : 2'(acr_pkg::RATE_MANUAL);

    // Comparator channel fields.
    assign cmp_src[0] = ctrl_q[acr_pkg::CMP1_LSB +: 3]; // [R04]
    assign cmp_src[1] = src_q[acr_pkg::CMP2_LSB +: 3]; // [R05]
    assign cmp_src[2] = src_q[acr_pkg::CMP3_LSB +: 3]; // [R06]

    // Primary control; a host write of one wins over the completion clear.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_q <= acr_pkg::CTRL_PRIMARY_RST; // [R04]
        end else if (wr_ctrl) begin
            ctrl_q <= i_reg_req.wdata; // [R01] [R02] [R03] [R04]
        end else if (tmr_done) begin
            ctrl_q[acr_pkg::TRIG_BIT] <= 1'b0; // [R02]
        end
    end

    // Comparator source control; the two low bits are kept as written.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            src_q <= acr_pkg::CMP_SOURCE_RST; // [R05] [R06]
        end else if (wr_src) begin
            src_q <= i_reg_req.wdata; // [R05] [R06]
        end
    end

    // A conversion is launched from idle by the trigger or by an automatic rate.
    assign start = (state_q == ST_IDLE) &&
                   ((rate_eff != 2'(acr_pkg::RATE_MANUAL)) || trig); // [R01] [R02]

    // Scheduler: converting, then waiting out the period in the timed rates.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (tmr_done) begin
                        if (rate_eff == 2'(acr_pkg::RATE_SEC) ||
                            rate_eff == 2'(acr_pkg::RATE_MIN)) begin
                            state_q <= ST_WAIT; // [R01]
                        end else begin
                            state_q <= ST_IDLE; // [R01]
                        end
                    end
                end
                ST_WAIT: begin
                    // Leaving one cycle early makes start-to-start exactly one period.
                    if (period_q <= W'(1) || rate_eff == 2'(acr_pkg::RATE_MANUAL) ||
                        rate_eff == 2'(acr_pkg::RATE_CONT)) begin
                        state_q <= ST_IDLE; // [R01]
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Period counter, measured from one start to the next.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            period_q <= '0;
        end else if (start) begin
            if (rate_eff == 2'(acr_pkg::RATE_MIN)) begin
                period_q <= P_MIN_CYC - W'(1); // [R01]
            end else begin
                period_q <= P_SEC_CYC - W'(1); // [R01]
            end
        end else if (period_q != '0) begin
            period_q <= period_q - W'(1);
        end
    end

    acr_conv_timer #(
        .P_CYC0(P_CONV0_CYC),
        .P_CYC1(P_CONV1_CYC),
        .P_CYC2(P_CONV2_CYC),
        .P_CYC3(P_CONV3_CYC)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_start(start),
        .i_speed(ctrl_q[acr_pkg::SPEED_LSB +: 2]),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    // All channels are captured in one edge so high and low bytes always match.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            results_q <= '0;
        end else if (tmr_done) begin
            results_q <= i_samples; // [R13]
        end
    end

    // Completion pulse for the surrounding logic.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= tmr_done;
        end
    end

    // Picks a channel's fresh measurement by its code.
    function automatic logic [15:0] pick(input acr_pkg::acr_samples_s s, input logic [2:0] c);
        logic [15:0] v;
        v = 16'h0000;
        unique case (c)
            3'h0: v = 16'h0000;
            3'h1: v = s.aux;
            3'h2: v = s.therm;
            3'h3: v = s.vbat;
            3'h4: v = s.ichg;
            3'h5: v = s.supply_input_voltage;
            3'h6: v = s.rail;
            3'h7: v = s.input_current;
        endcase
        return v;
    endfunction

    // Three comparators, each judging the conversion that just ended.
    for (genvar g = 0; g < 3; g++) begin : g_cmp
        acr_comparator u_cmp (
            .i_ref_clk(i_ref_clk),
            .i_srst(i_srst),
            .i_eval(tmr_done),
            .i_source(cmp_src[g]),
            .i_value(pick(i_samples, cmp_src[g])),
            .i_thresh(i_cmp_thresh[g]),
            .i_polarity(i_cmp_polarity[g]),
            .i_flag_clr(i_cmp_flag_clr[g]),
            .o_flag(o_cmp_flag[g]),
            .o_event(o_cmp_irq[g])
        );
    end

    // Read port: one cycle of latency, unmapped offsets read as zero.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_reg_req.rd;
            if (i_reg_req.rd) begin
                unique case (i_reg_req.addr)
                    acr_pkg::ADDR_CTRL_PRIMARY: rdata_q <= ctrl_q;
                    acr_pkg::ADDR_CMP_SOURCE: rdata_q <= src_q;
                    acr_pkg::ADDR_VBAT_HI: rdata_q <= results_q.vbat[15:8]; // [R07]
                    acr_pkg::ADDR_VBAT_LO: rdata_q <= results_q.vbat[7:0]; // [R07]
                    acr_pkg::ADDR_THERM_HI: rdata_q <= results_q.therm[15:8]; // [R08]
                    acr_pkg::ADDR_THERM_LO: rdata_q <= results_q.therm[7:0]; // [R08]
                    acr_pkg::ADDR_ICHG_HI: rdata_q <= results_q.ichg[15:8]; // [R09]
                    acr_pkg::ADDR_ICHG_LO: rdata_q <= results_q.ichg[7:0]; // [R09]
                    acr_pkg::ADDR_AUX_HI: rdata_q <= results_q.aux[15:8]; // [R10]
                    acr_pkg::ADDR_AUX_LO: rdata_q <= results_q.aux[7:0]; // [R10]
                    acr_pkg::ADDR_VIN_HI: rdata_q <= results_q.supply_input_voltage[15:8]; // [R11]
                    acr_pkg::ADDR_VIN_LO: rdata_q <= results_q.supply_input_voltage[7:0]; // [R11]
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;
    assign o_conv_busy = tmr_busy;
    assign o_conv_done = done_q;

    // Cycles since the last start, and whether the rate has held since; read by checks only.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            gap_q <= '0;
            gap_rate_q <= 2'(acr_pkg::RATE_MANUAL);
            gap_ok_q <= 1'b0;
        end else if (start) begin
            gap_q <= W'(1);
            gap_rate_q <= rate_eff;
            gap_ok_q <= 1'b1;
        end else begin
            gap_q <= gap_q + W'(1);
            gap_ok_q <= gap_ok_q && (rate_eff == gap_rate_q);
        end
    end

    chk_trig_self_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R02]
        tmr_done && !wr_ctrl |=> !trig)
        else $error("trigger bit not cleared after conversion");

    chk_manual_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R01]
        state_q == ST_IDLE && rate_eff == 2'(acr_pkg::RATE_MANUAL) && !trig |=> !tmr_busy)
        else $error("manual mode converted without a trigger");

    chk_trig_launch: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R02]
        state_q == ST_IDLE && trig |=> tmr_busy)
        else $error("trigger did not launch a conversion");

    chk_cont_restart: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R01]
        tmr_done && rate_eff == 2'(acr_pkg::RATE_CONT) && !i_reg_req.wr
        ##1 rate_eff == 2'(acr_pkg::RATE_CONT) |=> tmr_busy)
        else $error("continuous mode did not restart");

    chk_wait_no_conv: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R01]
        state_q == ST_WAIT |-> !tmr_busy && period_q <= P_MIN_CYC)
        else $error("conversion ran during the wait period");

    chk_result_pairs: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R13]
        tmr_done |=> results_q == $past(i_samples))
        else $error("results not taken from one conversion");

    chk_vbat_read: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R07]
        i_reg_req.rd && i_reg_req.addr == acr_pkg::ADDR_VBAT_HI
        |=> o_reg_rvalid && o_reg_rdata == $past(results_q.vbat[15:8]))
        else $error("battery high byte read wrong");

    chk_source_reset: assert property (@(posedge i_ref_clk) // [R05]
        $past(i_srst) && !i_srst |-> src_q == acr_pkg::CMP_SOURCE_RST
        && ctrl_q == acr_pkg::CTRL_PRIMARY_RST)
        else $error("control registers not at reset value");

    // Timed rates assume a conversion shorter than the period, true for every speed code.
    chk_second_spacing: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R01]
        start && gap_ok_q && rate_eff == gap_rate_q && rate_eff == 2'(acr_pkg::RATE_SEC)
        |-> gap_q == P_SEC_CYC)
        else $error("one-second rate spacing wrong");

    chk_minute_spacing: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R01]
        start && gap_ok_q && rate_eff == gap_rate_q && rate_eff == 2'(acr_pkg::RATE_MIN)
        |-> gap_q == P_MIN_CYC)
        else $error("one-minute rate spacing wrong");

    chk_source_write: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R05] [R06]
        wr_src |=> src_q == $past(i_reg_req.wdata))
        else $error("source register did not take the written value");

endmodule

// [testbench/acr_fe_model.sv]
module acr_fe_model (
    input wire logic i_ref_clk, // Core clock.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire logic i_conv_done, // Pulse after each conversion.
    output acr_pkg::acr_samples_s o_samples // Front-end values.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] count_q;

    // Counts finished conversions, so that each conversion sees fresh values.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            count_q <= 12'h000;
        end else if (i_conv_done) begin
            count_q <= count_q + 12'h001;
        end
    end

    // Each channel shows its index in the top nibble and the count below it.
    assign o_samples = {4'h1, count_q, 4'h2, count_q, 4'h3, count_q, 4'h4, count_q,
                        4'h5, count_q, 4'h6, count_q, 4'h7, count_q};
endmodule

// [testbench/acr_top_tb.sv]
module acr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [acr_pkg::CNT_W-1:0] CYC [4] = '{40'h8, 40'h6, 40'h4, 40'h3};
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    acr_pkg::acr_reg_req_s req = '0;
    acr_pkg::acr_samples_s samples;
    logic [7:0] rdata;
    logic rvalid, busy, done;
    logic bat_only = 1'b0;
    logic [2:0][15:0] thresh = {16'hffff, 16'hffff, 16'h0000};
    logic [2:0] pol = 3'b001;
    logic [2:0] clr = 3'b000;
    logic [2:0] flag, irq, irq_seen;
    int fails = 0;
    int checked = 0;
    int nconv = 0;

    // The clock toggles every half period of 5 ns.
    always #5 i_ref_clk = ~i_ref_clk;

    acr_top #(.P_CONV0_CYC(CYC[0]), .P_CONV1_CYC(CYC[1]), .P_CONV2_CYC(CYC[2]),
        .P_CONV3_CYC(CYC[3]), .P_SEC_CYC(40'h28), .P_MIN_CYC(40'h50)) dut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_req(req), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_bat_only(bat_only), .i_samples(samples),
        .i_cmp_thresh(thresh), .i_cmp_polarity(pol), .i_cmp_flag_clr(clr),
        .o_cmp_flag(flag), .o_cmp_irq(irq), .o_conv_busy(busy), .o_conv_done(done));

    acr_fe_model u_fe (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_conv_done(done),
        .o_samples(samples));

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_ref_clk) #1;
        req = '0;
    endtask

    // The read data and its valid pulse are due one cycle after the request.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_ref_clk) #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_ref_clk) #1;
        req = '0;
        chk({7'h00, rvalid, rdata}, {8'h01, e});
    endtask

    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge i_ref_clk) #1;
            n++;
        end while (done !== 1'b1 && n < 300);
        if (done !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    // One manual conversion, then its timing, trigger bit and all results.
    task automatic conv(input logic [1:0] code, input logic [2:0] exp_irq);
        int n;
        n = 0;
        irq_seen = 3'b000;
        wr(8'h40, 8'h22 | {3'b000, code, 3'b000});
        for (int i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge i_ref_clk) #1;
            n += int'(busy);
            irq_seen |= irq;
        end
        if (done !== 1'b1) begin
            fails++;
            end_sim();
        end
        chk(16'(n), 16'(CYC[code]));
        chk(16'(irq_seen), 16'(exp_irq));
        rd(8'h40, 8'h02 | {3'b000, code, 3'b000});
        for (int i = 0; i < 5; i++) begin
            rd(8'h42 + 8'(2 * i), 8'((i + 1) << 4));
            rd(8'h43 + 8'(2 * i), 8'(nconv));
        end
        nconv++;
    endtask

    // Spacing of completions once the chosen read rate has settled.
    task automatic period(input logic [7:0] ctrl, input int exp);
        int n;
        wr(8'h40, ctrl);
        repeat (3) wait_done(n);
        chk(16'(n), 16'(exp));
    endtask

    task automatic quiet();
        int n;
        n = 0;
        repeat (100) begin
            @(posedge i_ref_clk) #1;
            n += int'(done);
        end
        chk(16'(n), 16'h0000);
    endtask

    // Main sequence: reset values, refusals, conversions, comparators, rates.
    initial begin
        repeat (16) @(posedge i_ref_clk);
        #1 i_srst = 1'b0;
        rd(8'h40, 8'h02);
        rd(8'h41, 8'h40);
        rd(8'h50, 8'h00);
        wr(8'h42, 8'h5a);
        rd(8'h42, 8'h00);
        conv(2'b00, 3'b011);
        chk(16'(flag), 16'h0003);
        clr = 3'b111;
        @(posedge i_ref_clk) #1;
        clr = 3'b000;
        wr(8'h41, 8'h4f);
        rd(8'h41, 8'h4f);
        chk(16'(flag), 16'h0000);
        conv(2'b01, 3'b100);
        chk(16'(flag), 16'h0004);
        conv(2'b10, 3'b000);
        conv(2'b11, 3'b000);
        bat_only = 1'b1;
        quiet();
        period(8'h5a, 4);
        period(8'h9a, 40);
        period(8'hda, 80);
        bat_only = 1'b0;
        repeat (10) @(posedge i_ref_clk);
        quiet();
        end_sim();
    end
endmodule
